// ===== hw/pfl_effort_limiter.sv
`timescale 1ns/10ps
module pfl_effort_limiter (
  input  wire logic signed [15:0] rawEffort,
  input  wire logic signed [8:0]  fwdLow,
  input  wire logic signed [8:0]  fwdHigh,
  input  wire logic signed [8:0]  bwdLow,
  input  wire logic signed [8:0]  bwdHigh,
  output logic signed [8:0]       limited
);
  always_comb
  begin
    limited = pfl_pkg::EFFORT_ZERO;
    if (rawEffort > 16'sh0000)
    begin
      if (rawEffort < fwdLow)
        limited = pfl_pkg::EFFORT_ZERO;
      else if (rawEffort > fwdHigh)
        limited = fwdHigh;
      else
        limited = rawEffort[8:0];
    end
    else if (rawEffort < 16'sh0000)
    begin
      if (rawEffort > bwdLow)
        limited = pfl_pkg::EFFORT_ZERO;
      else if (rawEffort < bwdHigh)
        limited = bwdHigh;
      else
        limited = rawEffort[8:0];
    end
  end
endmodule

// ===== hw/pfl_ms_tick.sv
`timescale 1ns/10ps
module pfl_ms_tick #(
  parameter int CYCLES = pfl_pkg::MS_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  output logic      tick
);
  logic [31:0] count;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      count <= 32'h0;
      tick  <= 1'b0;
    end
    else if (count == 32'(CYCLES - 1))
    begin
      count <= 32'h0;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule

// ===== hw/pfl_pkg.sv
package pfl_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_SETPOINT = 8'h00;
  localparam logic [7:0] OFF_CONV     = 8'h04;
  localparam logic [7:0] OFF_POS_LOW  = 8'h08;
  localparam logic [7:0] OFF_POS_HIGH = 8'h0c;
  localparam logic [7:0] OFF_FWD_LOW  = 8'h10;
  localparam logic [7:0] OFF_FWD_HIGH = 8'h14;
  localparam logic [7:0] OFF_BWD_LOW  = 8'h18;
  localparam logic [7:0] OFF_BWD_HIGH = 8'h1c;
  localparam logic [7:0] OFF_SAMPLE   = 8'h20;
  localparam logic [7:0] OFF_DIRECT   = 8'h24;
  localparam logic [7:0] OFF_MODE     = 8'h28;
  localparam logic [7:0] OFF_POSITION = 8'h2c;

  // actuator mode codes
  localparam logic [1:0] MODE_DIRECT_ZERO = 2'h0;
  localparam logic [1:0] MODE_DIRECT_RUN  = 2'h1;
  localparam logic [1:0] MODE_FEEDBACK    = 2'h2;

  // effort range
  localparam logic signed [8:0] EFFORT_MAX  = 9'sh0ff;
  localparam logic signed [8:0] EFFORT_MIN  = -9'sh0ff;
  localparam logic signed [8:0] EFFORT_ZERO = 9'sh000;

  // reset values
  localparam logic signed [15:0] POS_LOW_RST  = 16'sh0000;
  localparam logic signed [15:0] POS_HIGH_RST = 16'sh03ff;
  localparam logic signed [8:0]  FWD_LOW_RST  = 9'sh000;
  localparam logic signed [8:0]  FWD_HIGH_RST = 9'sh0ff;
  localparam logic signed [8:0]  BWD_LOW_RST  = 9'sh000;
  localparam logic signed [8:0]  BWD_HIGH_RST = -9'sh0ff;
  localparam logic signed [31:0] CONV_RST     = 32'sh00000064;
  localparam logic [15:0]        SAMPLE_RST   = 16'h000a;

  // timing
  localparam int CLK_HZ    = 200_000_000;
  localparam int TICK_MS   = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // response channels
  typedef enum logic [3:0] {
    CH_SETPOINT, CH_CONV, CH_POS_LOW, CH_POS_HIGH, CH_FWD_LOW,
    CH_FWD_HIGH, CH_BWD_LOW, CH_BWD_HIGH, CH_SAMPLE, CH_EFFORT,
    CH_MODE, CH_POSITION
  } pfl_ch_t;

  typedef enum logic {RS_IDLE, RS_SEND} pfl_rsp_state_t;

endpackage

// ===== hw/pfl_top.sv
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - setpoint write enters feedback mode
// - setpoint clamped into position limits
// - reply setpoint, then mode 2
// - on stop reply position, setpoint, mode
// - setpoint read returns held target
// - convergence timeout write rejects negatives
// - zero timeout disables convergence detection
// - stop after zero effort for timeout
// - stall or run timer also stops
// - low position limit not above high
// - high position limit not below low
// - forward min within backward min, forward max
// - forward max within forward min, 255
// - backward min within backward max, forward min
// - backward max within -255, backward min
// - forward effort below minimum brakes
// - forward effort capped at maximum
// - weak backward effort brakes
// - backward effort capped at maximum
// - parameter writes answered, reads return value
// - mode codes 0, 1, 2
// - effort confined to -255..255
// - output recomputed once per sample interval
module pfl_top #(
  parameter int MS_CYCLES = pfl_pkg::MS_CYCLES
) (
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic signed [15:0] position,
  input  wire logic signed [15:0] pidEffort,
  input  wire logic               stallExpired,
  input  wire logic               runTimerExpired,
  output logic                    sampleStrobe,
  output logic signed [8:0]       motorEffort,
  output logic                    feedbackActive,
  output logic                    rspValid,
  input  wire logic               rspReady,
  output pfl_pkg::pfl_ch_t        rspChannel,
  output logic [31:0]             rspValue
);
  function automatic logic isMapped(input logic [7:0] a, input logic wr);
    logic ok;
    ok = 1'b1;
    case (a)
      pfl_pkg::OFF_SETPOINT, pfl_pkg::OFF_CONV, pfl_pkg::OFF_POS_LOW,
      pfl_pkg::OFF_POS_HIGH, pfl_pkg::OFF_FWD_LOW, pfl_pkg::OFF_FWD_HIGH,
      pfl_pkg::OFF_BWD_LOW, pfl_pkg::OFF_BWD_HIGH, pfl_pkg::OFF_SAMPLE,
      pfl_pkg::OFF_DIRECT: ok = 1'b1;
      pfl_pkg::OFF_MODE, pfl_pkg::OFF_POSITION: ok = !wr;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  logic signed [15:0] posLow;
  logic signed [15:0] posHigh;
  logic signed [8:0]  fwdLow;
  logic signed [8:0]  fwdHigh;
  logic signed [8:0]  bwdLow;
  logic signed [8:0]  bwdHigh;
  logic signed [31:0] convTimeout;
  logic [15:0]        sampleInterval;
  logic signed [15:0] target;
  logic [15:0]        sampleCount;
  logic [31:0]        convCount;
  logic               stopPending;
  logic               msTick;
  logic signed [8:0]  limitedEffort;
  pfl_pkg::pfl_rsp_state_t rspState;
  pfl_pkg::pfl_ch_t   qCh [0:2];
  logic [31:0]        qVal [0:2];
  logic [1:0]         qLen;

  logic               rspBusy;
  logic               access;
  logic               wrDone;
  logic               stopGo;
  logic               converged;
  logic               stopEvent;
  logic               sampleDue;
  logic signed [31:0] wd;
  logic signed [15:0] clampedSp;
  logic signed [8:0]  clampedDirect;
  logic [1:0]         modeCode;
  logic [31:0]        wrResult;
  pfl_pkg::pfl_ch_t   wrChannel;
  logic accPosLow, accPosHigh, accFwdLow, accFwdHigh;
  logic accBwdLow, accBwdHigh, accConv, accSample;

  pfl_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tick    (msTick)
  );

  pfl_effort_limiter u_limit (
    .rawEffort (pidEffort),
    .fwdLow    (fwdLow),
    .fwdHigh   (fwdHigh),
    .bwdLow    (bwdLow),
    .bwdHigh   (bwdHigh),
    .limited   (limitedEffort)
  );

  assign wd      = signed'(pwdata);
  assign rspBusy = (rspState != pfl_pkg::RS_IDLE);
  assign access  = psel && penable;
  // writes stall while replies are queued or a stop is awaiting its replies
  assign pready  = !pwrite || (!rspBusy && !stopPending);
  assign pslverr = access && !isMapped(paddr, pwrite);
  assign wrDone  = access && pwrite && pready && isMapped(paddr, 1'b1);
  assign stopGo  = stopPending && !rspBusy;

  assign accPosLow  = wd <= posHigh;
  assign accPosHigh = wd >= posLow;
  assign accFwdLow  = wd >= bwdLow && wd <= fwdHigh;
  assign accFwdHigh = wd >= fwdLow && wd <= pfl_pkg::EFFORT_MAX;
  assign accBwdLow  = wd >= bwdHigh && wd <= fwdLow;
  assign accBwdHigh = wd <= bwdLow && wd >= pfl_pkg::EFFORT_MIN;
  assign accConv    = wd >= 32'sh0;
  assign accSample  = wd > 32'sh0 && pwdata[31:16] == 16'h0;

  always_comb
  begin
    clampedSp = wd[15:0];
    if (wd < posLow)
      clampedSp = posLow;
    else if (wd > posHigh)
      clampedSp = posHigh;
    clampedDirect = wd[8:0];
    if (wd > pfl_pkg::EFFORT_MAX)
      clampedDirect = pfl_pkg::EFFORT_MAX;
    else if (wd < pfl_pkg::EFFORT_MIN)
      clampedDirect = pfl_pkg::EFFORT_MIN;
  end

  assign modeCode = feedbackActive ? pfl_pkg::MODE_FEEDBACK :
                    (motorEffort != pfl_pkg::EFFORT_ZERO) ?
                    pfl_pkg::MODE_DIRECT_RUN : pfl_pkg::MODE_DIRECT_ZERO;

  // resulting value of a parameter write, for its reply
  always_comb
  begin
    wrChannel = pfl_pkg::CH_SETPOINT;
    wrResult  = 32'h0;
    case (paddr)
      pfl_pkg::OFF_CONV:
      begin
        wrChannel = pfl_pkg::CH_CONV;
        wrResult  = accConv ? pwdata : convTimeout;
      end
      pfl_pkg::OFF_POS_LOW:
      begin
        wrChannel = pfl_pkg::CH_POS_LOW;
        wrResult  = accPosLow ? pwdata : 32'(posLow);
      end
      pfl_pkg::OFF_POS_HIGH:
      begin
        wrChannel = pfl_pkg::CH_POS_HIGH;
        wrResult  = accPosHigh ? pwdata : 32'(posHigh);
      end
      pfl_pkg::OFF_FWD_LOW:
      begin
        wrChannel = pfl_pkg::CH_FWD_LOW;
        wrResult  = accFwdLow ? pwdata : 32'(fwdLow);
      end
      pfl_pkg::OFF_FWD_HIGH:
      begin
        wrChannel = pfl_pkg::CH_FWD_HIGH;
        wrResult  = accFwdHigh ? pwdata : 32'(fwdHigh);
      end
      pfl_pkg::OFF_BWD_LOW:
      begin
        wrChannel = pfl_pkg::CH_BWD_LOW;
        wrResult  = accBwdLow ? pwdata : 32'(bwdLow);
      end
      pfl_pkg::OFF_BWD_HIGH:
      begin
        wrChannel = pfl_pkg::CH_BWD_HIGH;
        wrResult  = accBwdHigh ? pwdata : 32'(bwdHigh);
      end
      pfl_pkg::OFF_SAMPLE:
      begin
        wrChannel = pfl_pkg::CH_SAMPLE;
        wrResult  = accSample ? pwdata : 32'(sampleInterval);
      end
      default:
      begin
        wrChannel = pfl_pkg::CH_SETPOINT;
        wrResult  = 32'(target);
      end
    endcase
  end

  // parameter storage; rejected values leave the old one in place
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      posLow         <= pfl_pkg::POS_LOW_RST;
      posHigh        <= pfl_pkg::POS_HIGH_RST;
      fwdLow         <= pfl_pkg::FWD_LOW_RST;
      fwdHigh        <= pfl_pkg::FWD_HIGH_RST;
      bwdLow         <= pfl_pkg::BWD_LOW_RST;
      bwdHigh        <= pfl_pkg::BWD_HIGH_RST;
      convTimeout    <= pfl_pkg::CONV_RST;
      sampleInterval <= pfl_pkg::SAMPLE_RST;
    end
    else if (wrDone)
    begin
      case (paddr)
        pfl_pkg::OFF_POS_LOW:  if (accPosLow) posLow <= wd[15:0];
        pfl_pkg::OFF_POS_HIGH: if (accPosHigh) posHigh <= wd[15:0];
        pfl_pkg::OFF_FWD_LOW:  if (accFwdLow) fwdLow <= wd[8:0];
        pfl_pkg::OFF_FWD_HIGH: if (accFwdHigh) fwdHigh <= wd[8:0];
        pfl_pkg::OFF_BWD_LOW:  if (accBwdLow) bwdLow <= wd[8:0];
        pfl_pkg::OFF_BWD_HIGH: if (accBwdHigh) bwdHigh <= wd[8:0];
        pfl_pkg::OFF_CONV:     if (accConv) convTimeout <= wd;
        pfl_pkg::OFF_SAMPLE:   if (accSample) sampleInterval <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // control mode, target and commanded effort
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      feedbackActive <= 1'b0;
      target         <= pfl_pkg::POS_LOW_RST;
      motorEffort    <= pfl_pkg::EFFORT_ZERO;
    end
    else if (wrDone && paddr == pfl_pkg::OFF_SETPOINT)
    begin
      feedbackActive <= 1'b1;
      target         <= clampedSp;
      motorEffort    <= pfl_pkg::EFFORT_ZERO;
    end
    else if (wrDone && paddr == pfl_pkg::OFF_DIRECT)
    begin
      feedbackActive <= 1'b0;
      motorEffort    <= clampedDirect;
    end
    else if (stopGo)
      feedbackActive <= 1'b0;
    else if (stopEvent || stopPending)
      motorEffort <= pfl_pkg::EFFORT_ZERO;
    else if (sampleDue)
      motorEffort <= limitedEffort;
  end

  // sample interval timing in milliseconds
  assign sampleDue = feedbackActive && !stopPending && msTick &&
                     (sampleCount + 16'h1 >= sampleInterval);

  always_ff @(posedge sys_clk)
  begin
    if (reset || !feedbackActive || stopPending)
      sampleCount <= 16'h0;
    else if (sampleDue)
      sampleCount <= 16'h0;
    else if (msTick)
      sampleCount <= sampleCount + 16'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      sampleStrobe <= 1'b0;
    else
      sampleStrobe <= sampleDue;
  end

  // consecutive milliseconds of zero commanded effort
  always_ff @(posedge sys_clk)
  begin
    if (reset || !feedbackActive || motorEffort != pfl_pkg::EFFORT_ZERO)
      convCount <= 32'h0;
    else if (wrDone && paddr == pfl_pkg::OFF_SETPOINT)
      convCount <= 32'h0;
    else if (msTick && convCount != 32'hffffffff)
      convCount <= convCount + 32'h1;
  end

  assign converged = convTimeout > 32'sh0 &&
                     convCount >= unsigned'(convTimeout);
  assign stopEvent = feedbackActive &&
                     (converged || stallExpired || runTimerExpired);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      stopPending <= 1'b0;
    else if (stopGo)
      stopPending <= 1'b0;
    else if (stopEvent)
      stopPending <= 1'b1;
  end

  // reply queue: head entry drives the response port
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rspState <= pfl_pkg::RS_IDLE;
      qLen     <= 2'h0;
      for (int i = 0; i < 3; i++)
      begin
        qCh[i]  <= pfl_pkg::CH_SETPOINT;
        qVal[i] <= 32'h0;
      end
    end
    else
    begin
      case (rspState)
        pfl_pkg::RS_IDLE:
        begin
          if (stopGo)
          begin
            rspState <= pfl_pkg::RS_SEND;
            qLen     <= 2'h3;
            qCh[0]   <= pfl_pkg::CH_POSITION;
            qVal[0]  <= 32'(position);
            qCh[1]   <= pfl_pkg::CH_SETPOINT;
            qVal[1]  <= 32'(target);
            qCh[2]   <= pfl_pkg::CH_MODE;
            qVal[2]  <= 32'(pfl_pkg::MODE_DIRECT_ZERO);
          end
          else if (wrDone && paddr == pfl_pkg::OFF_SETPOINT)
          begin
            rspState <= pfl_pkg::RS_SEND;
            qLen     <= 2'h2;
            qCh[0]   <= pfl_pkg::CH_SETPOINT;
            qVal[0]  <= 32'(clampedSp);
            qCh[1]   <= pfl_pkg::CH_MODE;
            qVal[1]  <= 32'(pfl_pkg::MODE_FEEDBACK);
          end
          else if (wrDone && paddr == pfl_pkg::OFF_DIRECT)
          begin
            rspState <= pfl_pkg::RS_SEND;
            qLen     <= 2'h2;
            qCh[0]   <= pfl_pkg::CH_EFFORT;
            qVal[0]  <= 32'(clampedDirect);
            qCh[1]   <= pfl_pkg::CH_MODE;
            qVal[1]  <= (clampedDirect == pfl_pkg::EFFORT_ZERO) ?
                        32'(pfl_pkg::MODE_DIRECT_ZERO) :
                        32'(pfl_pkg::MODE_DIRECT_RUN);
          end
          else if (wrDone)
          begin
            rspState <= pfl_pkg::RS_SEND;
            qLen     <= 2'h1;
            qCh[0]   <= wrChannel;
            qVal[0]  <= wrResult;
          end
        end
        pfl_pkg::RS_SEND:
        begin
          if (rspReady)
          begin
            if (qLen == 2'h1)
              rspState <= pfl_pkg::RS_IDLE;
            qLen    <= qLen - 2'h1;
            qCh[0]  <= qCh[1];
            qVal[0] <= qVal[1];
            qCh[1]  <= qCh[2];
            qVal[1] <= qVal[2];
          end
        end
        default: rspState <= pfl_pkg::RS_IDLE;
      endcase
    end
  end

  assign rspValid   = (rspState == pfl_pkg::RS_SEND);
  assign rspChannel = qCh[0];
  assign rspValue   = qVal[0];

  // read data is captured in the setup cycle and shown in the access cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        pfl_pkg::OFF_SETPOINT: prdata <= 32'(target);
        pfl_pkg::OFF_CONV:     prdata <= convTimeout;
        pfl_pkg::OFF_POS_LOW:  prdata <= 32'(posLow);
        pfl_pkg::OFF_POS_HIGH: prdata <= 32'(posHigh);
        pfl_pkg::OFF_FWD_LOW:  prdata <= 32'(fwdLow);
        pfl_pkg::OFF_FWD_HIGH: prdata <= 32'(fwdHigh);
        pfl_pkg::OFF_BWD_LOW:  prdata <= 32'(bwdLow);
        pfl_pkg::OFF_BWD_HIGH: prdata <= 32'(bwdHigh);
        pfl_pkg::OFF_SAMPLE:   prdata <= 32'(sampleInterval);
        pfl_pkg::OFF_DIRECT:   prdata <= 32'(motorEffort);
        pfl_pkg::OFF_MODE:     prdata <= 32'(modeCode);
        pfl_pkg::OFF_POSITION: prdata <= 32'(position);
        default:               prdata <= 32'h0;
      endcase
    end
  end
endmodule

// ===== sim/pfl_host_model.sv
`timescale 1ns/10ps
module pfl_host_model (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic        rspValid,
  input  wire logic [3:0]  rspChannel,
  input  wire logic [31:0] rspValue,
  output logic             rspReady
);
  logic [3:0]  gotCh[$];
  logic [31:0] gotVal[$];
  // a slow host takes a reply only every other cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      rspReady <= 1'b0;
    else
      rspReady <= slow ? !rspReady : 1'b1;
  end
  always @(posedge sys_clk)
  begin
    if (!reset && rspValid && rspReady)
    begin
      gotCh.push_back(rspChannel);
      gotVal.push_back(rspValue);
    end
  end
endmodule

// ===== sim/pfl_top_monitor.sv
`timescale 1ns/10ps
module pfl_top_monitor #(
  parameter int MS_CYCLES = pfl_pkg::MS_CYCLES
) (
  input wire logic               sys_clk,
  input wire logic               reset,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               stallExpired,
  input wire logic               runTimerExpired,
  input wire logic               sampleStrobe,
  input wire logic signed [8:0]  motorEffort,
  input wire logic               feedbackActive,
  input wire logic               rspValid,
  input wire logic               rspReady,
  input wire pfl_pkg::pfl_ch_t   rspChannel,
  input wire logic [31:0]        rspValue
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic spWr;
  logic took;
  assign spWr = psel && penable && pwrite && pready
    && paddr == pfl_pkg::OFF_SETPOINT;
  assign took = rspValid && rspReady;
  mode_enter_a: assert property (spWr |=> feedbackActive)
    else $error("setpoint write did not enter feedback");
  sp_reply_a: assert property (spWr |=> rspValid
    && rspChannel == pfl_pkg::CH_SETPOINT)
    else $error("setpoint reply missing");
  mode_follow_a: assert property (took
    && rspChannel == pfl_pkg::CH_SETPOINT
    |=> rspValid && rspChannel == pfl_pkg::CH_MODE)
    else $error("mode reply does not follow setpoint");
  stop_order_a: assert property (took
    && rspChannel == pfl_pkg::CH_POSITION
    |=> rspValid && rspChannel == pfl_pkg::CH_SETPOINT)
    else $error("setpoint reply does not follow position");
  mode_code_a: assert property (rspValid
    && rspChannel == pfl_pkg::CH_MODE |->
    (feedbackActive ? rspValue == 32'h2 : rspValue < 32'h2))
    else $error("bad mode code");
  stop_brake_a: assert property (feedbackActive
    && (stallExpired || runTimerExpired)
    |-> ##[1:2] motorEffort == pfl_pkg::EFFORT_ZERO)
    else $error("effort not zero after stop");
  effort_range_a: assert property (motorEffort >= pfl_pkg::EFFORT_MIN
    && motorEffort <= pfl_pkg::EFFORT_MAX)
    else $error("effort out of range");
  strobe_pulse_a: assert property (sampleStrobe |=> !sampleStrobe)
    else $error("sample strobe longer than one cycle");
  bad_addr_a: assert property (psel && penable
    && paddr > pfl_pkg::OFF_POSITION |-> pslverr)
    else $error("unmapped access not refused");
  read_ready_a: assert property (psel && penable && !pwrite
    |-> pready)
    else $error("read not answered at once");
endmodule

// ===== sim/pfl_top_tb.sv
`timescale 1ns/10ps
module pfl_top_tb;
  localparam int MS = 20;
  logic               sys_clk, reset, psel, penable, pwrite, slow, err;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd, rspValue;
  logic               pready, pslverr, sampleStrobe, feedbackActive;
  logic               rspValid, rspReady, stallExpired, runTimerExpired;
  logic signed [15:0] position, pidEffort;
  logic signed [8:0]  motorEffort;
  pfl_pkg::pfl_ch_t   rspChannel;
  int                 n_fail, cmp_count;
  pfl_top #(.MS_CYCLES(MS)) dut (.sys_clk(sys_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .position(position), .pidEffort(pidEffort),
    .stallExpired(stallExpired), .runTimerExpired(runTimerExpired),
    .sampleStrobe(sampleStrobe), .motorEffort(motorEffort),
    .feedbackActive(feedbackActive), .rspValid(rspValid),
    .rspReady(rspReady), .rspChannel(rspChannel), .rspValue(rspValue));
  pfl_host_model host (.sys_clk(sys_clk), .reset(reset), .slow(slow),
    .rspValid(rspValid), .rspChannel(rspChannel), .rspValue(rspValue),
    .rspReady(rspReady));
  task automatic report_and_stop();
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    // only the watchdog ends a wait for a stalled write
    while (pready !== 1'b1)
      @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rsp(input logic [3:0] ch, input logic [31:0] v);
    int i;
    for (i = 0; i < 500 && host.gotCh.size() == 0; i++)
      @(posedge sys_clk);
    if (host.gotCh.size() == 0)
      check(32'h0, 32'h1);
    else
    begin
      check({28'h0, host.gotCh.pop_front()}, {28'h0, ch});
      check(host.gotVal.pop_front(), v);
    end
  endtask
  // parameter reply channels follow register order
  task automatic lim(input logic [7:0] a, input logic [31:0] w, e);
    apb(1'b1, a, w);
    rsp(a[5:2], e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic eff(input logic signed [15:0] p,
                     input logic signed [8:0] e);
    int i;
    int k;
    pidEffort <= p;
    for (k = 0; k < 2; k++)
    begin
      @(posedge sys_clk);
      for (i = 0; i < 200 && sampleStrobe !== 1'b1; i++)
        @(posedge sys_clk);
      check({31'h0, sampleStrobe}, 32'h1);
    end
    check({23'h0, motorEffort}, {23'h0, e});
  endtask
  task automatic t_reset();
    apb(1'b0, pfl_pkg::OFF_POS_HIGH, 32'h0);
    check(rd, 32'h3ff);
    apb(1'b0, pfl_pkg::OFF_BWD_HIGH, 32'h0);
    check(rd, -32'sh0ff);
    apb(1'b0, pfl_pkg::OFF_MODE, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, pfl_pkg::OFF_MODE, 32'h1);
    check({31'h0, err}, 32'h1);
  endtask
  task automatic t_limits();
    lim(pfl_pkg::OFF_POS_LOW, 32'h7d0, 32'h0);
    lim(pfl_pkg::OFF_POS_LOW, 32'h14, 32'h14);
    lim(pfl_pkg::OFF_POS_HIGH, 32'ha, 32'h3ff);
    lim(pfl_pkg::OFF_POS_HIGH, 32'h190, 32'h190);
    lim(pfl_pkg::OFF_POS_LOW, 32'h191, 32'h14);
    lim(pfl_pkg::OFF_FWD_HIGH, 32'h100, 32'hff);
    lim(pfl_pkg::OFF_FWD_HIGH, 32'hc8, 32'hc8);
    lim(pfl_pkg::OFF_FWD_LOW, 32'hc9, 32'h0);
    lim(pfl_pkg::OFF_FWD_LOW, 32'h28, 32'h28);
    lim(pfl_pkg::OFF_FWD_HIGH, 32'h27, 32'hc8);
    lim(pfl_pkg::OFF_BWD_LOW, 32'h29, 32'h0);
    lim(pfl_pkg::OFF_BWD_LOW, -32'sh14, -32'sh14);
    lim(pfl_pkg::OFF_FWD_LOW, -32'sh15, 32'h28);
    lim(pfl_pkg::OFF_BWD_HIGH, -32'sh100, -32'sh0ff);
    lim(pfl_pkg::OFF_BWD_HIGH, -32'sh13, -32'sh0ff);
    lim(pfl_pkg::OFF_BWD_HIGH, -32'sh96, -32'sh96);
    lim(pfl_pkg::OFF_CONV, -32'sh5, 32'h64);
    lim(pfl_pkg::OFF_CONV, 32'h0, 32'h0);
    lim(pfl_pkg::OFF_SAMPLE, 32'h1, 32'h1);
  endtask
  task automatic t_setpoint(input logic [31:0] w, e);
    apb(1'b1, pfl_pkg::OFF_SETPOINT, w);
    check({31'h0, feedbackActive}, 32'h1);
    check({23'h0, motorEffort}, 32'h0);
    rsp(pfl_pkg::CH_SETPOINT, e);
    rsp(pfl_pkg::CH_MODE, 32'h2);
    apb(1'b0, pfl_pkg::OFF_SETPOINT, 32'h0);
    check(rd, e);
  endtask
  task automatic t_effort();
    eff(16'sh001e, 9'sh000);
    eff(16'sh0028, 9'sh028);
    eff(16'sh012c, 9'sh0c8);
    eff(-16'sh000a, 9'sh000);
    eff(-16'sh0014, -9'sh014);
    eff(-16'sh0190, -9'sh096);
    eff(16'sh0000, 9'sh000);
    repeat (10 * MS) @(posedge sys_clk);
    check({31'h0, feedbackActive}, 32'h1);
  endtask
  task automatic t_stop(input logic s, st, input logic [31:0] sp);
    slow <= s;
    position <= 16'sh007b;
    stallExpired <= st;
    runTimerExpired <= !st;
    @(posedge sys_clk);
    stallExpired <= 1'b0;
    runTimerExpired <= 1'b0;
    rsp(pfl_pkg::CH_POSITION, 32'h7b);
    rsp(pfl_pkg::CH_SETPOINT, sp);
    rsp(pfl_pkg::CH_MODE, 32'h0);
    check({31'h0, feedbackActive}, 32'h0);
  endtask
  task automatic t_direct();
    apb(1'b1, pfl_pkg::OFF_DIRECT, 32'h12c);
    check({31'h0, feedbackActive}, 32'h0);
    rsp(pfl_pkg::CH_EFFORT, 32'hff);
    rsp(pfl_pkg::CH_MODE, 32'h1);
    check({23'h0, motorEffort}, 32'hff);
    apb(1'b0, pfl_pkg::OFF_MODE, 32'h0);
    check(rd, 32'h1);
  endtask
  task automatic t_converge();
    int n;
    lim(pfl_pkg::OFF_CONV, 32'h3, 32'h3);
    t_setpoint(32'h64, 32'h64);
    for (n = 0; n < 300 && feedbackActive === 1'b1; n++)
      @(posedge sys_clk);
    check({31'h0, n >= 30 && n <= 3 * MS}, 32'h1);
    rsp(pfl_pkg::CH_POSITION, 32'h7b);
    rsp(pfl_pkg::CH_SETPOINT, 32'h64);
    rsp(pfl_pkg::CH_MODE, 32'h0);
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    reset = 1'b1;
    {psel, penable, pwrite, slow, stallExpired, runTimerExpired} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    position = 16'sh0000;
    pidEffort = 16'sh0000;
    n_fail = 0;
    cmp_count = 0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_limits();
    t_setpoint(32'h1388, 32'h190);
    t_effort();
    t_stop(1'b1, 1'b1, 32'h190);
    t_setpoint(-32'sh7, 32'h14);
    t_stop(1'b0, 1'b0, 32'h14);
    t_direct();
    t_converge();
    report_and_stop();
  end
endmodule
bind pfl_top pfl_top_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
  .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .stallExpired(stallExpired), .runTimerExpired(runTimerExpired),
  .sampleStrobe(sampleStrobe), .motorEffort(motorEffort),
  .feedbackActive(feedbackActive), .rspValid(rspValid),
  .rspReady(rspReady), .rspChannel(rspChannel), .rspValue(rspValue));
